// *** verilog/cpi_pkg.sv ***
// Purpose: Shared constants and carriers for the card PIN and record increment core
// Assumes: One command in flight; terminal framing and file selection happen upstream
// Notes:   Functional notes below, one line per behaviour
//
// Functional notes
// - A PIN check with data compares it against the stored reference of that key.
// - Comparison happens only when the addressed PIN is neither disabled nor blocked.
// - PIN-protected file operations are refused until verified, unless the PIN is disabled; the core answers search without this check.
// - A correct comparison restores the remaining-attempts counter to three.
// - A wrong comparison decrements the shared counter, whatever the channel.
// - First wrong presentation answers 63C2.
// - Second wrong presentation answers 63C1; the counter survives card resets.
// - Third wrong presentation blocks the PIN and answers 63C0.
// - Any later valued check on a blocked PIN answers 6983 without comparing.
// - A blocked PIN leaves protected access unfulfilled until an unblock succeeds.
// - A check with empty data only reports the counter selected by P2.
// - The empty-data query works even when the PIN is disabled or blocked.
// - Remaining retries are reported as 63CX with X the count.
// - An empty-data query on a blocked PIN answers 63C0.
// - Increment on a listed file with unmet access condition answers 6982 and leaves the file alone.
// - Increment adds the operand to the newest record and writes the oldest.
// - After increment the written record becomes record one.
// - Increment answers the new record value followed by the added value.
// - A sum beyond all-ones stores nothing and answers 9850.
// - Increment on a file whose rule lacks the instruction answers an error.
// - Search with empty expected length returns no data and 9000.
// - Search with nonzero expected length returns at most that many record numbers.

`default_nettype none

package cpi_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PIN_NUM = 2;
  localparam int PSEL_W = 1;
  localparam int PIN_BYTES = 8;
  localparam int DATA_W = 8 * PIN_BYTES;
  localparam int REC_LEN = 3;
  localparam int REC_NUM = 4;
  localparam int PTR_W = 2;
  localparam int RSP_MAX = 2 * REC_LEN;
  localparam int LEN_W = 3;
  localparam int CTR_W = 2;
  localparam int PSEL_BIT = 7;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [CTR_W-1:0] CTR_INIT = 2'h3;
  localparam logic [CTR_W-1:0] CTR_ZERO = 2'h0;
  localparam logic [7:0] LC_PIN = 8'h08;
  localparam logic [7:0] LC_REC = 8'h03;
  localparam logic [7:0] LC_NONE = 8'h00;
  localparam logic [LEN_W-1:0] LEN_INC = 3'h6;
  localparam logic [PTR_W-1:0] PTR_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] INS_UNBLOCK = 8'h2C;
  localparam logic [7:0] INS_INCREMENT = 8'h32;
  localparam logic [7:0] INS_SEARCH = 8'hA2;
  localparam logic [7:0] INS_READ = 8'hB0;
  localparam logic [7:0] INS_UPDATE = 8'hDC;

  // ----------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_RETRY = 16'h63C0;
  localparam logic [15:0] SW_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_DISABLED = 16'h6984;
  localparam logic [15:0] SW_SECURITY = 16'h6982;
  localparam logic [15:0] SW_NOT_ALLOWED = 16'h6986;
  localparam logic [15:0] SW_MAX_REACHED = 16'h9850;
  localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
  localparam logic [15:0] SW_BAD_INS = 16'h6D00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ins;
    logic [7:0] p2;
    logic [7:0] lc;
    logic [DATA_W-1:0] data;
    logic le_present;
    logic [7:0] le;
    logic [REC_NUM-1:0] match;
  } cpi_cmd_t;

  typedef struct packed {
    logic [15:0] sw;
    logic [LEN_W-1:0] len;
    logic [8*RSP_MAX-1:0] data;
  } cpi_rsp_t;

  typedef struct packed {
    logic inc_listed;
    logic ac_is_pin;
    logic [PSEL_W-1:0] ac_pin;
  } cpi_file_t;

endpackage : cpi_pkg

`default_nettype wire

// *** verilog/cpi_rec_mem.sv ***
// Purpose: Record store of the cyclic file, one record per word
// Assumes: Single port; a write and a read never share a cycle
// Notes:   Contents are not cleared by reset, like the card's non-volatile store

`default_nettype none

module cpi_rec_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 24,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Access port
  input wire logic we,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem_reg[addr] <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= mem_reg[addr];
    end
  end

endmodule : cpi_rec_mem

`default_nettype wire

// *** verilog/cpi_rec_add.sv ***
// Purpose: Unsigned big-endian record adder with overflow flag
// Assumes: Byte 0 of the vector is the least significant, last on the wire
// Notes:   Ripple carry per byte; three bytes settle well inside one cycle

`default_nettype none

module cpi_rec_add #(
  parameter int BYTES = 3
) (
  // Operands
  input wire logic [8*BYTES-1:0] a,
  input wire logic [8*BYTES-1:0] b,
  // Result
  output logic [8*BYTES-1:0] sum,
  output logic ovf
);

  logic [BYTES:0] carry;

  assign carry[0] = 1'b0;

  for (genvar g = 0; g < BYTES; g++) begin : g_byte
    assign {carry[g+1], sum[8*g +: 8]} = {1'b0, a[8*g +: 8]} + {1'b0, b[8*g +: 8]} + {8'h00, carry[g]};
  end

  assign ovf = carry[BYTES];

endmodule : cpi_rec_add

`default_nettype wire

// *** verilog/cpi_cmd_core.sv ***
// Purpose: PIN check, retry counter, record increment and search length limiting
// Assumes: Commands arrive on sys_clk already decoded from the terminal's frames
// Notes:   pwr_rst models first power-up of the non-volatile counters and pointer

`default_nettype none

module cpi_cmd_core
  import cpi_pkg::*;
(
  // Clock and resets
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic pwr_rst,
  // Command from the terminal
  input wire logic cmd_valid,
  input wire cpi_cmd_t cmd,
  output logic cmd_ready,
  // Response to the terminal
  output logic rsp_valid,
  output cpi_rsp_t rsp,
  // Card context
  input wire logic [PIN_NUM-1:0] pin_disabled,
  input wire logic [PIN_NUM-1:0][DATA_W-1:0] pin_ref,
  input wire cpi_file_t file_attr,
  // Security state
  output logic [PIN_NUM-1:0] pin_blocked,
  output logic [PIN_NUM-1:0] pin_verified
);

  // ----------------------------------------------------------------
  // Types and functions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_CALC = 2'b10
  } cpi_state_t;

  function automatic logic [PSEL_W-1:0] pin_sel(input logic [7:0] p2);
    return p2[PSEL_BIT];
  endfunction : pin_sel

  function automatic logic [PTR_W-1:0] older(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] r;
    r = (p == '0) ? PTR_LAST : p - 1'b1;
    return r;
  endfunction : older

  // 63CX: the low nibble carries the attempts left
  function automatic logic [15:0] retry_sw(input logic [CTR_W-1:0] c);
    return SW_RETRY | 16'(c);
  endfunction : retry_sw

  // Match bit k stands for record k+1, listed in ascending search order
  function automatic cpi_rsp_t build_list(
    input logic [REC_NUM-1:0] mask,
    input logic present,
    input logic [7:0] lim
  );
    cpi_rsp_t r;
    r = '0;
    r.sw = SW_OK;
    for (int k = 0; k < REC_NUM; k++) begin
      if (present && mask[k] && (lim == LC_NONE || 8'(r.len) < lim)) begin
        r.data[8*RSP_MAX-1-8*r.len -: 8] = 8'(k + 1);
        r.len = r.len + 1'b1;
      end
    end
    return r;
  endfunction : build_list

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cpi_state_t state_reg;
  cpi_state_t state_next;
  logic ready_reg;
  logic rsp_valid_reg;
  cpi_rsp_t rsp_reg;
  cpi_rsp_t rsp_d;
  logic rsp_fire;
  logic [CTR_W-1:0] ctr_reg [PIN_NUM];
  logic [PIN_NUM-1:0] ver_reg;
  logic [PIN_NUM-1:0] blocked_reg;
  logic [PIN_NUM-1:0] verified_reg;
  logic [PTR_W-1:0] newest_reg;
  logic [PTR_W-1:0] newest_next;
  logic [8*REC_LEN-1:0] opnd_reg;
  logic [8*REC_LEN-1:0] opnd_next;

  // ----------------------------------------------------------------
  // Record store and adder
  // ----------------------------------------------------------------
  logic mem_we;
  logic mem_rd;
  logic [PTR_W-1:0] mem_addr;
  logic [8*REC_LEN-1:0] mem_wdata;
  logic [8*REC_LEN-1:0] mem_rdata;
  logic [8*REC_LEN-1:0] sum;
  logic ovf;

  // Single port is enough: the read and the write of an increment are a cycle apart
  cpi_rec_mem #(
    .DEPTH(REC_NUM),
    .WIDTH(8 * REC_LEN),
    .AW(PTR_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .we(mem_we),
    .rd_en(mem_rd),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  cpi_rec_add #(
    .BYTES(REC_LEN)
  ) u_add (
    .a(mem_rdata),
    .b(opnd_reg),
    .sum(sum),
    .ovf(ovf)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic take = cmd_valid && ready_reg;
  wire logic is_verify = cmd.ins == INS_VERIFY;
  wire logic is_unblock = cmd.ins == INS_UNBLOCK;
  wire logic is_inc = cmd.ins == INS_INCREMENT;
  wire logic is_search = cmd.ins == INS_SEARCH;
  wire logic is_read = cmd.ins == INS_READ;
  wire logic is_update = cmd.ins == INS_UPDATE;
  wire logic has_data = cmd.lc != LC_NONE;
  wire logic [PSEL_W-1:0] vsel = pin_sel(cmd.p2);
  wire logic [PSEL_W-1:0] asel = file_attr.ac_pin;
  wire logic [CTR_W-1:0] v_ctr = ctr_reg[vsel];
  wire logic [CTR_W-1:0] v_ctr_dec = v_ctr - 1'b1;
  wire logic v_blocked = v_ctr == CTR_ZERO;
  wire logic v_dis = pin_disabled[vsel];
  wire logic v_len_ok = cmd.lc == LC_PIN;
  wire logic v_match = cmd.data == pin_ref[vsel];
  wire logic [PTR_W-1:0] oldest = older(newest_reg);
  wire logic rec_op = is_inc || is_update;
  wire logic rec_len_ok = cmd.lc == LC_REC;
  wire cpi_rsp_t search_rsp = build_list(cmd.match, cmd.le_present, cmd.le);

  // Comparison only on a usable PIN; blocked never compares
  wire logic v_usable = !v_dis && !v_blocked;
  wire logic v_cmp = take && is_verify && has_data && v_usable && v_len_ok;
  wire logic v_good = v_cmp && v_match;
  wire logic v_bad = v_cmp && !v_match;
  wire logic v_unblock = take && is_unblock;

  // A blocked PIN has counter zero, so it can never count as verified
  wire logic ac_pin_ok = ver_reg[asel] && (ctr_reg[asel] != CTR_ZERO);
  wire logic ac_met = !file_attr.ac_is_pin || pin_disabled[asel] || ac_pin_ok;

  // ----------------------------------------------------------------
  // Increment result
  // ----------------------------------------------------------------
  // Operand is held in a register so the command may change after the take
  wire logic inc_store = !ovf;
  wire logic [8*RSP_MAX-1:0] inc_data = {sum, opnd_reg};

  // ----------------------------------------------------------------
  // Status word of a PIN check
  // ----------------------------------------------------------------
  logic [15:0] verify_sw;

  always_comb begin
    if (!has_data) begin
      verify_sw = retry_sw(v_ctr);
    end else if (v_blocked) begin
      verify_sw = SW_BLOCKED;
    end else if (v_dis) begin
      verify_sw = SW_DISABLED;
    end else if (!v_len_ok) begin
      verify_sw = SW_WRONG_LEN;
    end else if (v_match) begin
      verify_sw = SW_OK;
    end else begin
      verify_sw = retry_sw(v_ctr_dec);
    end
  end

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    rsp_d = '0;
    rsp_fire = 1'b0;
    mem_we = 1'b0;
    mem_rd = 1'b0;
    mem_addr = newest_reg;
    mem_wdata = cmd.data[8*REC_LEN-1:0];
    newest_next = newest_reg;
    opnd_next = opnd_reg;
    case (state_reg)
      S_IDLE: begin
        if (take) begin
          rsp_fire = 1'b1;
          if (is_verify) begin
            rsp_d.sw = verify_sw;
          end else if (is_search) begin
            rsp_d = search_rsp;
          end else if (is_read) begin
            rsp_d.sw = ac_met ? SW_OK : SW_SECURITY;
          end else if (is_unblock) begin
            rsp_d.sw = SW_OK;
          end else if (is_inc && !file_attr.inc_listed) begin
            rsp_d.sw = SW_NOT_ALLOWED;
          end else if (rec_op && !ac_met) begin
            rsp_d.sw = SW_SECURITY;
          end else if (rec_op && !rec_len_ok) begin
            rsp_d.sw = SW_WRONG_LEN;
          end else if (is_inc) begin
            // Fetch the newest record; the answer comes after the add
            rsp_fire = 1'b0;
            mem_rd = 1'b1;
            opnd_next = cmd.data[8*REC_LEN-1:0];
            state_next = S_CALC;
          end else if (is_update) begin
            mem_we = 1'b1;
            mem_addr = oldest;
            newest_next = oldest;
            rsp_d.sw = SW_OK;
          end else begin
            rsp_d.sw = SW_BAD_INS;
          end
        end
      end
      S_CALC: begin
        rsp_fire = 1'b1;
        state_next = S_IDLE;
        // Overflow leaves both the store and the pointer alone
        if (!inc_store) begin
          rsp_d.sw = SW_MAX_REACHED;
        end else begin
          mem_we = 1'b1;
          mem_addr = oldest;
          mem_wdata = sum;
          newest_next = oldest;
          rsp_d.sw = SW_OK;
          rsp_d.len = LEN_INC;
          rsp_d.data = inc_data;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and response registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
      opnd_reg <= '0;
    end else begin
      state_reg <= state_next;
      ready_reg <= state_next == S_IDLE;
      rsp_valid_reg <= rsp_fire;
      opnd_reg <= opnd_next;
      if (rsp_fire) begin
        rsp_reg <= rsp_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Record pointer
  // ----------------------------------------------------------------
  // Record one survives card resets, like the record contents
  always_ff @(posedge sys_clk) begin
    if (pwr_rst) begin
      newest_reg <= '0;
    end else begin
      newest_reg <= newest_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-PIN counters and security state
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PIN_NUM; i++) begin : g_pin
    wire logic hit = vsel == PSEL_W'(i);
    wire logic ctr_load = hit && (v_good || v_unblock);
    wire logic ctr_step = hit && v_bad;
    wire logic ver_load = hit && v_cmp;
    wire logic at_zero = ctr_reg[i] == CTR_ZERO;

    // Counter is non-volatile and shared by every channel
    always_ff @(posedge sys_clk) begin
      if (pwr_rst) begin
        ctr_reg[i] <= CTR_INIT;
      end else if (ctr_load) begin
        ctr_reg[i] <= CTR_INIT;
      end else if (ctr_step) begin
        ctr_reg[i] <= ctr_reg[i] - 1'b1;
      end
    end

    // Verified state lasts one card session only
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        ver_reg[i] <= 1'b0;
      end else if (ver_load) begin
        ver_reg[i] <= v_match;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        blocked_reg[i] <= 1'b0;
        verified_reg[i] <= 1'b0;
      end else begin
        blocked_reg[i] <= at_zero;
        verified_reg[i] <= ver_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp = rsp_reg;
  assign pin_blocked = blocked_reg;
  assign pin_verified = verified_reg;

endmodule : cpi_cmd_core

`default_nettype wire

// *** tb/cpi_cmd_core_asserts.sv ***
// Purpose: Port checks for the command core
// Assumes: Bound to cpi_cmd_core
// Notes:   State outputs lag a command by two edges, hence settled
`default_nettype none
module cpi_cmd_core_chk
  import cpi_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Command and response
  input wire logic cmd_valid,
  input wire cpi_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire cpi_rsp_t rsp,
  // Context and state
  input wire logic [PIN_NUM-1:0] pin_disabled,
  input wire logic [PIN_NUM-1:0][DATA_W-1:0] pin_ref,
  input wire cpi_file_t file_attr,
  input wire logic [PIN_NUM-1:0] pin_blocked,
  input wire logic [PIN_NUM-1:0] pin_verified
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] busy_reg;
  wire take = cmd_valid && cmd_ready;
  wire settled = busy_reg == 2'h0;
  wire vfy0 = take && settled && cmd.ins == INS_VERIFY && !cmd.p2[PSEL_BIT] && !pin_disabled[0];
  wire locked = file_attr.ac_is_pin && !pin_disabled[file_attr.ac_pin] && !pin_verified[file_attr.ac_pin];
  wire inc = take && cmd.ins == INS_INCREMENT;
  wire srch = take && cmd.ins == INS_SEARCH;
  always_ff @(posedge sys_clk) begin
    busy_reg <= {busy_reg[0], take || sys_rst};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_pin_ok: assert property (
    vfy0 && cmd.lc == LC_PIN && !pin_blocked[0] && cmd.data == pin_ref[0] |=> rsp_valid && rsp.sw == SW_OK)
    else $error("correct code refused");
  chk_pin_bad: assert property (
    vfy0 && cmd.lc == LC_PIN && !pin_blocked[0] && cmd.data != pin_ref[0]
      |=> rsp_valid && rsp.sw[15:4] == 12'h63C ##1 !pin_verified[0])
    else $error("wrong code accepted");
  chk_pin_locked: assert property (
    vfy0 && cmd.lc == LC_PIN && pin_blocked[0] |=> rsp_valid && rsp.sw == SW_BLOCKED)
    else $error("blocked code compared");
  chk_query_blocked: assert property (
    take && settled && cmd.ins == INS_VERIFY && cmd.lc == LC_NONE && !cmd.p2[PSEL_BIT] && pin_blocked[0]
      |=> rsp_valid && rsp.sw == SW_RETRY)
    else $error("blocked query wrong");
  chk_access_deny: assert property (
    take && settled && cmd.ins == INS_READ && locked |=> rsp_valid && rsp.sw == SW_SECURITY)
    else $error("unverified access granted");
  chk_inc_guard: assert property (
    inc && settled && locked && file_attr.inc_listed |=> rsp_valid && rsp.sw == SW_SECURITY)
    else $error("unverified increment");
  chk_inc_unlisted: assert property (
    inc && !file_attr.inc_listed |=> rsp_valid && rsp.sw == SW_NOT_ALLOWED)
    else $error("unlisted increment");
  chk_inc_result: assert property (
    rsp_valid && rsp.sw == SW_OK && $past(inc, 2) && !$past(take)
      |-> rsp.len == LEN_INC && rsp.data[23:0] == $past(cmd.data[23:0], 2))
    else $error("increment answer wrong");
  chk_inc_timing: assert property (
    inc && settled && file_attr.inc_listed && !locked && cmd.lc == LC_REC
      |=> (!cmd_ready && !rsp_valid) ##1 (rsp_valid && cmd_ready))
    else $error("increment timing wrong");
  chk_search_empty: assert property (
    srch && !cmd.le_present |=> rsp_valid && rsp.len == 3'h0 && rsp.sw == SW_OK)
    else $error("search without length gave data");
  chk_search_limit: assert property (
    srch && cmd.le_present && cmd.le != 8'h00 |=> rsp_valid && {5'h00, rsp.len} <= $past(cmd.le))
    else $error("search list too long");
endmodule : cpi_cmd_core_chk

bind cpi_cmd_core cpi_cmd_core_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pin_disabled(pin_disabled),
  .pin_ref(pin_ref), .file_attr(file_attr), .pin_blocked(pin_blocked), .pin_verified(pin_verified));
`default_nettype wire

// *** tb/cpi_term_model.sv ***
// Purpose: Terminal model, one command then its answer
// Assumes: Called just after a rising edge
// Notes:   Two idle edges after each answer; released fields invert
`default_nettype none
module cpi_term_model
  import cpi_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Command
  output var logic cmd_valid,
  output var cpi_cmd_t cmd,
  input wire logic cmd_ready,
  // Response
  input wire logic rsp_valid,
  input wire cpi_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic issue(input cpi_cmd_t c, output cpi_rsp_t r, output logic ok);
    int n;
    logic got;
    ok = 1'b0;
    got = 1'b0;
    cmd_valid <= 1'b1;
    cmd <= c;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge sys_clk);
      ok = cmd_ready;
    end
    cmd_valid <= 1'b0;
    cmd <= cpi_cmd_t'(~c);
    for (n = 0; n < 4 && !got; n++) begin
      @(posedge sys_clk);
      got = rsp_valid;
    end
    r = rsp;
    ok = ok && got;
    repeat (2) @(posedge sys_clk);
  endtask : issue
endmodule : cpi_term_model
`default_nettype wire

// *** tb/cpi_cmd_core_bench.sv ***
// Purpose: Self-checking bench for the command core
// Assumes: Terminal model spaces the commands
// Notes:   Records survive reset, so one update seeds them
`default_nettype none
module cpi_cmd_core_bench
  import cpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] PIN_A = 64'h1122334455667788;
  localparam logic [63:0] PIN_B = 64'h8877665544332211;
  localparam logic [63:0] BAD = 64'h0;
  logic sys_clk;
  logic sys_rst;
  logic pwr_rst;
  logic cmd_valid;
  logic cmd_ready;
  logic rsp_valid;
  cpi_cmd_t cmd;
  cpi_rsp_t rsp;
  cpi_rsp_t last_rsp;
  cpi_file_t file_attr;
  logic [PIN_NUM-1:0] pin_disabled;
  logic [PIN_NUM-1:0] pin_blocked;
  logic [PIN_NUM-1:0] pin_verified;
  logic [PIN_NUM-1:0][DATA_W-1:0] pin_ref;
  int n_errors;
  int samples_checked;

  cpi_cmd_core u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .pwr_rst(pwr_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pin_disabled(pin_disabled), .pin_ref(pin_ref),
    .file_attr(file_attr), .pin_blocked(pin_blocked), .pin_verified(pin_verified));
  cpi_term_model u_term (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] ins, input logic [7:0] p2, input logic [7:0] lc, input logic [63:0] d,
      input logic [8:0] le, input logic [3:0] hit);
    logic ok;
    u_term.issue('{ins, p2, lc, d, le[8], le[7:0], hit}, last_rsp, ok);
    if (!ok) begin
      n_errors++;
      $display("FAIL %0t no answer", $time);
    end
  endtask : send

  task automatic xfer(input logic [7:0] ins, input logic [7:0] p2, input logic [7:0] lc, input logic [63:0] d,
      input logic [15:0] sw);
    send(ins, p2, lc, d, 9'h000, 4'h0);
    check(last_rsp.sw, sw);
  endtask : xfer

  task automatic inc_ok(input logic [23:0] op, input logic [23:0] nv);
    xfer(INS_INCREMENT, 8'h00, LC_REC, {40'h0, op}, SW_OK);
    check(last_rsp.len, LEN_INC);
    check(last_rsp.data, {nv, op});
  endtask : inc_ok

  task automatic srch(input logic [8:0] le, input logic [3:0] hit, input logic [2:0] n, input logic [31:0] exp);
    send(INS_SEARCH, 8'h00, LC_NONE, BAD, le, hit);
    check(last_rsp.sw, SW_OK);
    check(last_rsp.len, n);
    check(last_rsp.data >> (48 - 8 * n), exp);
  endtask : srch

  task automatic card_reset(input logic pwr);
    sys_rst <= 1'b1;
    pwr_rst <= pwr;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pwr_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : card_reset

  task automatic test_increment;
    file_attr <= '{1'b1, 1'b0, 1'b0};
    xfer(INS_UPDATE, 8'h00, LC_REC, 64'h000001, SW_OK);
    file_attr <= '{1'b1, 1'b1, 1'b0};
    xfer(INS_INCREMENT, 8'h00, LC_REC, 64'h000002, SW_SECURITY);
    xfer(INS_VERIFY, 8'h01, LC_PIN, PIN_A, SW_OK);
    inc_ok(24'h000003, 24'h000004);
    inc_ok(24'h010200, 24'h010204);
    xfer(INS_INCREMENT, 8'h00, LC_REC, 64'hFF0000, SW_MAX_REACHED);
    inc_ok(24'h00FFFD, 24'h020201);
    file_attr <= '{1'b0, 1'b1, 1'b0};
    xfer(INS_INCREMENT, 8'h00, LC_REC, 64'h010200, SW_NOT_ALLOWED);
  endtask : test_increment

  task automatic test_pin;
    xfer(INS_VERIFY, 8'h01, LC_PIN, BAD, 16'h63C2);
    xfer(INS_VERIFY, 8'h01, LC_NONE, BAD, 16'h63C2);
    check(pin_verified, 2'h0);
    xfer(INS_VERIFY, 8'h81, LC_PIN, BAD, 16'h63C2);
    xfer(INS_VERIFY, 8'h81, LC_PIN, PIN_B, SW_OK);
    xfer(INS_VERIFY, 8'h01, LC_PIN, PIN_A, SW_OK);
    xfer(INS_VERIFY, 8'h01, LC_NONE, BAD, 16'h63C3);
    xfer(INS_VERIFY, 8'h01, LC_PIN, BAD, 16'h63C2);
    xfer(INS_VERIFY, 8'h01, LC_PIN, BAD, 16'h63C1);
    card_reset(1'b0);
    xfer(INS_VERIFY, 8'h01, LC_PIN, BAD, SW_RETRY);
    check(pin_blocked, 2'h1);
    xfer(INS_VERIFY, 8'h01, LC_PIN, BAD, SW_BLOCKED);
    xfer(INS_VERIFY, 8'h01, LC_PIN, PIN_A, SW_BLOCKED);
    xfer(INS_VERIFY, 8'h01, LC_NONE, BAD, SW_RETRY);
    xfer(INS_READ, 8'h00, LC_NONE, BAD, SW_SECURITY);
    xfer(INS_UNBLOCK, 8'h01, LC_NONE, BAD, SW_OK);
    xfer(INS_VERIFY, 8'h01, LC_NONE, BAD, 16'h63C3);
  endtask : test_pin

  task automatic test_disabled;
    pin_disabled <= 2'h1;
    xfer(INS_READ, 8'h00, LC_NONE, BAD, SW_OK);
    xfer(INS_VERIFY, 8'h01, LC_PIN, PIN_A, SW_DISABLED);
    xfer(INS_VERIFY, 8'h01, LC_NONE, BAD, 16'h63C3);
    pin_disabled <= 2'h0;
    xfer(INS_READ, 8'h00, LC_NONE, BAD, SW_SECURITY);
    xfer(INS_VERIFY, 8'h01, LC_PIN, PIN_A, SW_OK);
    xfer(INS_READ, 8'h00, LC_NONE, BAD, SW_OK);
  endtask : test_disabled

  task automatic test_search;
    srch(9'h000, 4'hF, 3'h0, 32'h0);
    srch(9'h101, 4'hF, 3'h1, 32'h01);
    srch(9'h104, 4'hF, 3'h4, 32'h01020304);
    srch(9'h104, 4'h6, 3'h2, 32'h0203);
    srch(9'h101, 4'h0, 3'h0, 32'h0);
    srch(9'h100, 4'hB, 3'h3, 32'h010204);
  endtask : test_search

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run is well under 1000 edges
  initial begin
    repeat (5000) @(posedge sys_clk);
    $display("FAIL %0t watchdog expired", $time);
    n_errors++;
    finish_test;
  end

  initial begin
    n_errors = 0;
    samples_checked = 0;
    pin_disabled = 2'h0;
    pin_ref = {PIN_B, PIN_A};
    file_attr = '{1'b1, 1'b0, 1'b0};
    card_reset(1'b1);
    test_increment;
    test_pin;
    test_disabled;
    test_search;
    finish_test;
  end
endmodule : cpi_cmd_core_bench
`default_nettype wire
